// File: common/cft_pkg.sv
package cft_pkg;
	// APB geometry
	localparam int unsigned CFT_AW = 12;
	localparam int unsigned CFT_DW = 32;
	// Register byte offsets
	localparam logic [11:0] CFT_OFS_DATA = 12'h000;
	localparam logic [11:0] CFT_OFS_FEATURE = 12'h004;
	localparam logic [11:0] CFT_OFS_COUNT = 12'h008;
	localparam logic [11:0] CFT_OFS_SECTOR = 12'h00C;
	localparam logic [11:0] CFT_OFS_TRK_LO = 12'h010;
	localparam logic [11:0] CFT_OFS_TRK_HI = 12'h014;
	localparam logic [11:0] CFT_OFS_DEVHEAD = 12'h018;
	localparam logic [11:0] CFT_OFS_OPCODE = 12'h01C;
	localparam logic [11:0] CFT_OFS_ERROR = 12'h020;
	localparam logic [11:0] CFT_OFS_STATUS = 12'h024;
	localparam logic [11:0] CFT_OFS_IRQ_ST = 12'h028;
	localparam logic [11:0] CFT_OFS_IRQ_MASK = 12'h02C;
	// Opcodes
	localparam logic [7:0] CFT_OP_FLUSH = 8'hE7;
	localparam logic [7:0] CFT_OP_FLUSH_EXT = 8'hEA;
	localparam logic [7:0] CFT_OP_FMT_TRACK = 8'h50;
	// Drive/head fields
	localparam int unsigned CFT_DH_BLOCK_MODE = 6;
	localparam int unsigned CFT_DH_HEAD_MSB = 3;
	// Status bits
	localparam int unsigned CFT_ST_BUSY = 7;
	localparam int unsigned CFT_ST_READY = 6;
	localparam int unsigned CFT_ST_SEEKDONE = 4;
	localparam int unsigned CFT_ST_ERROR = 0;
	// Error cause bits
	localparam int unsigned CFT_ERR_ABORT = 2;
	localparam int unsigned CFT_ERR_IDNF = 4;
	// Interrupt status bits
	localparam int unsigned CFT_IRQ_W = 2;
	localparam int unsigned CFT_IRQ_DONE = 0;
	localparam int unsigned CFT_IRQ_ERR = 1;
	// Reset values
	localparam logic [7:0] CFT_TF_RST = 8'h00;
	localparam logic [7:0] CFT_DH_RST = 8'hA0;
	localparam logic [1:0] CFT_MASK_RST = 2'h0;
	localparam logic [31:0] CFT_ZERO_WORD = 32'h0000_0000;
	// Block address width
	localparam int unsigned CFT_LBA_W = 28;
	// Command and sequencer states
	typedef enum logic [1:0] {CFT_IDLE, CFT_FLUSH, CFT_FMT} cft_cmd_st_t;
	typedef enum logic [1:0] {CFT_FMT_IDLE, CFT_FMT_CHECK, CFT_FMT_WRITE} cft_fmt_st_t;
endpackage

// File: design/cft_cache_flush.sv
`timescale 1ns/1ps
module cft_cache_flush (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Command side
	input wire logic start,
	output logic done,
	// Cache side
	output logic cacheFlushReq,
	input wire logic cacheEmpty
);
	import cft_pkg::*;

	typedef struct packed {
		logic req;
		logic done;
	} cft_flush_s_t;

	localparam cft_flush_s_t FLUSH_RST = '{default: '0};

	cft_flush_s_t s_q;
	cft_flush_s_t s_d;

	// Request held until the cache reports no dirty data left
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (start) begin
			s_d.req = 1'b1;
		end else if (s_q.req && cacheEmpty) begin
			s_d.req = 1'b0;
			s_d.done = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s_q <= FLUSH_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign cacheFlushReq = s_q.req;
	assign done = s_q.done;

	property p_done_empty;
		@(posedge mclk) disable iff (!resetn)
		s_q.done |-> $past(s_q.req) && $past(cacheEmpty);
	endproperty
	a_done_empty: assert property (p_done_empty) else $error("flush done without empty cache");
endmodule

// File: design/cft_track_fmt.sv
`timescale 1ns/1ps
module cft_track_fmt #(
	parameter int unsigned SECT_PER_TRACK = 63
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Command side
	input wire logic start,
	input wire logic [cft_pkg::CFT_LBA_W-1:0] startLba,
	output logic done,
	output logic [cft_pkg::CFT_LBA_W-1:0] lastLba,
	// Media side
	output logic mediaWrReq,
	output logic [cft_pkg::CFT_LBA_W-1:0] mediaWrLba,
	output logic [cft_pkg::CFT_DW-1:0] mediaWrData,
	input wire logic mediaWrAck,
	input wire logic sectorGood
);
	import cft_pkg::*;

	localparam int unsigned IW = $clog2(SECT_PER_TRACK + 1);
	localparam logic [IW-1:0] LAST_IDX = IW'(SECT_PER_TRACK - 1);

	typedef struct packed {
		cft_fmt_st_t st;
		logic [IW-1:0] idx;
		logic [CFT_LBA_W-1:0] block_address;
		logic wrReq;
		logic [CFT_DW-1:0] wrData;
		logic done;
		logic [CFT_LBA_W-1:0] last;
	} cft_fmt_s_t;

	localparam cft_fmt_s_t FMT_RST = '{st: CFT_FMT_IDLE, default: '0};

	cft_fmt_s_t s_q;
	cft_fmt_s_t s_d;

	// Sectors walk in plain ascending order; no read path exists, so nothing is read back
	always_comb begin
		logic advance;
		advance = 1'b0;
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			CFT_FMT_IDLE: begin
				if (start) begin
					s_d.block_address = startLba;
					s_d.idx = '0;
					s_d.st = CFT_FMT_CHECK;
				end
			end
			CFT_FMT_CHECK: begin
				// Defective sectors are skipped, good ones get zeros
				if (sectorGood) begin
					s_d.wrReq = 1'b1;
					s_d.wrData = CFT_ZERO_WORD;
					s_d.st = CFT_FMT_WRITE;
				end else begin
					advance = 1'b1;
				end
			end
			CFT_FMT_WRITE: begin
				if (mediaWrAck) begin
					s_d.wrReq = 1'b0;
					advance = 1'b1;
				end
			end
			default: begin
				s_d.st = CFT_FMT_IDLE;
			end
		endcase
		if (advance) begin
			if (s_q.idx == LAST_IDX) begin
				s_d.done = 1'b1;
				s_d.last = s_q.block_address;
				s_d.st = CFT_FMT_IDLE;
			end else begin
				s_d.block_address = s_q.block_address + 1'b1;
				s_d.idx = s_q.idx + 1'b1;
				s_d.st = CFT_FMT_CHECK;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s_q <= FMT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign mediaWrReq = s_q.wrReq;
	assign mediaWrLba = s_q.block_address;
	assign mediaWrData = s_q.wrData;
	assign done = s_q.done;
	assign lastLba = s_q.last;

	property p_zero_data;
		@(posedge mclk) disable iff (!resetn)
		s_q.wrReq |-> s_q.wrData == CFT_ZERO_WORD;
	endproperty
	a_zero_data: assert property (p_zero_data) else $error("nonzero format data");

	property p_one_to_one;
		@(posedge mclk) disable iff (!resetn)
		s_q.st == CFT_FMT_WRITE && mediaWrAck && s_q.idx != LAST_IDX
		|=> s_q.block_address == $past(s_q.block_address) + 1'b1 && s_q.st == CFT_FMT_CHECK;
	endproperty
	a_one_to_one: assert property (p_one_to_one) else $error("sector order not sequential");
endmodule

// File: design/cft_cmd_core.sv
`timescale 1ns/1ps
// Functional notes
// - Opcode E7h written to the opcode register starts a flush of every cached write.
// - Opcode EAh starts the same flush and uses no parameter register contents.
// - A flush reports good completion only once the write cache holds nothing unwritten.
// - Opcode 50h formats exactly one logical track.
// - The track format writes zeros into every good sector of the selected track.
// - The track format never reads back the zeroed sectors.
// - A format table sector from the host is accepted and its descriptors ignored.
// - Every track is laid out the same way at 1:1 interleave.
// - In block mode the whole logical track holding the given address is formatted.
// - After a block mode format the last block address of the track is left in the registers.
// - A block address beyond the addressable range aborts the format with the abort flag.
module cft_cmd_core #(
	parameter int unsigned SECT_PER_TRACK = 63,
	parameter int unsigned HEADS = 16,
	parameter int unsigned CYLINDERS = 16383,
	parameter logic [27:0] MAX_LBA = 28'h0FF_FFFF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cft_pkg::CFT_AW-1:0] paddr,
	input wire logic [cft_pkg::CFT_DW-1:0] pwdata,
	output logic [cft_pkg::CFT_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Write cache
	output logic cacheFlushReq,
	input wire logic cacheEmpty,
	// Media write port
	output logic mediaWrReq,
	output logic [cft_pkg::CFT_LBA_W-1:0] mediaWrLba,
	output logic [cft_pkg::CFT_DW-1:0] mediaWrData,
	input wire logic mediaWrAck,
	input wire logic sectorGood,
	// Interrupt
	output logic irq
);
	import cft_pkg::*;

	typedef struct packed {
		cft_cmd_st_t st;
		logic [7:0] feature;
		logic [7:0] count;
		logic [7:0] sector;
		logic [7:0] trkLo;
		logic [7:0] trkHi;
		logic [7:0] devHead;
		logic [7:0] errCause;
		logic busy;
		logic errBit;
		logic lbaMode;
		logic [CFT_IRQ_W-1:0] irqSt;
		logic [CFT_IRQ_W-1:0] irqMask;
		logic flushGo;
		logic fmtGo;
		logic [CFT_LBA_W-1:0] trackLba;
		logic [CFT_DW-1:0] rdata;
		logic slvErr;
	} cft_core_s_t;

	localparam cft_core_s_t CORE_RST = '{
		st: CFT_IDLE,
		devHead: CFT_DH_RST,
		irqMask: CFT_MASK_RST,
		default: '0
	};

	cft_core_s_t s_q;
	cft_core_s_t s_d;

	logic flushDone;
	logic fmtDone;
	logic [CFT_LBA_W-1:0] fmtLast;

	// Bus decode
	logic setupRd;
	logic wrAcc;
	logic cmdWr;
	logic [7:0] opcode;
	logic [7:0] statusByte;
	assign setupRd = psel && !penable;
	assign wrAcc = psel && penable && pwrite;
	assign cmdWr = wrAcc && paddr == CFT_OFS_OPCODE && !s_q.busy;
	assign opcode = pwdata[7:0];

	// Status byte: ready and seek-complete stay up at all times, even with the error bit set
	always_comb begin
		statusByte = 8'h00;
		statusByte[CFT_ST_BUSY] = s_q.busy;
		statusByte[CFT_ST_READY] = 1'b1;
		statusByte[CFT_ST_SEEKDONE] = 1'b1;
		statusByte[CFT_ST_ERROR] = s_q.errBit;
	end

	// Target address as the host laid it out in either mode
	logic [CFT_LBA_W-1:0] reqLba;
	logic [15:0] reqCyl;
	logic [3:0] reqHead;
	logic [CFT_LBA_W-1:0] lbaTrack;
	logic [CFT_LBA_W-1:0] chsTrack;
	logic lbaBad;
	logic chsBad;
	logic lbaSel;
	assign reqLba = {s_q.devHead[CFT_DH_HEAD_MSB:0], s_q.trkHi, s_q.trkLo, s_q.sector};
	assign reqCyl = {s_q.trkHi, s_q.trkLo};
	assign reqHead = s_q.devHead[CFT_DH_HEAD_MSB:0];
	assign lbaSel = s_q.devHead[CFT_DH_BLOCK_MODE];
	// The modulo folds to constant logic; a power of two sectors count keeps it cheap
	assign lbaTrack = reqLba - CFT_LBA_W'(reqLba % SECT_PER_TRACK);
	assign chsTrack = CFT_LBA_W'((reqCyl * HEADS + reqHead) * SECT_PER_TRACK);
	assign lbaBad = reqLba > MAX_LBA;
	assign chsBad = reqCyl >= CYLINDERS || reqHead >= HEADS;

	// Whole register file: reads captured in setup, writes taken in access
	always_comb begin
		logic [CFT_DW-1:0] rd;
		logic mapped;
		rd = CFT_ZERO_WORD;
		mapped = 1'b1;
		s_d = s_q;
		s_d.flushGo = 1'b0;
		s_d.fmtGo = 1'b0;
		case (paddr)
			CFT_OFS_DATA: rd = CFT_ZERO_WORD;
			CFT_OFS_FEATURE: rd = CFT_ZERO_WORD;
			CFT_OFS_COUNT: rd[7:0] = s_q.count;
			CFT_OFS_SECTOR: rd[7:0] = s_q.sector;
			CFT_OFS_TRK_LO: rd[7:0] = s_q.trkLo;
			CFT_OFS_TRK_HI: rd[7:0] = s_q.trkHi;
			CFT_OFS_DEVHEAD: rd[7:0] = s_q.devHead;
			CFT_OFS_OPCODE: rd = CFT_ZERO_WORD;
			CFT_OFS_ERROR: rd[7:0] = s_q.errCause;
			CFT_OFS_STATUS: rd[7:0] = statusByte;
			CFT_OFS_IRQ_ST: rd[CFT_IRQ_W-1:0] = s_q.irqSt;
			CFT_OFS_IRQ_MASK: rd[CFT_IRQ_W-1:0] = s_q.irqMask;
			default: mapped = 1'b0;
		endcase
		if (setupRd) begin
			s_d.rdata = pwrite ? CFT_ZERO_WORD : rd;
			s_d.slvErr = !mapped;
		end
		// Command block is frozen while busy so the running command keeps its operands
		if (wrAcc && !s_q.busy) begin
			case (paddr)
				CFT_OFS_DATA: s_d.count = s_q.count;
				CFT_OFS_FEATURE: s_d.feature = pwdata[7:0];
				CFT_OFS_COUNT: s_d.count = pwdata[7:0];
				CFT_OFS_SECTOR: s_d.sector = pwdata[7:0];
				CFT_OFS_TRK_LO: s_d.trkLo = pwdata[7:0];
				CFT_OFS_TRK_HI: s_d.trkHi = pwdata[7:0];
				CFT_OFS_DEVHEAD: s_d.devHead = pwdata[7:0];
				default: s_d.feature = s_q.feature;
			endcase
		end
		if (wrAcc && paddr == CFT_OFS_IRQ_MASK) begin
			s_d.irqMask = pwdata[CFT_IRQ_W-1:0];
		end
		if (wrAcc && paddr == CFT_OFS_IRQ_ST) begin
			s_d.irqSt = s_q.irqSt & ~pwdata[CFT_IRQ_W-1:0];
		end
		// Opcode decode
		if (cmdWr) begin
			s_d.errCause = 8'h00;
			s_d.errBit = 1'b0;
			s_d.lbaMode = lbaSel;
			case (opcode)
				CFT_OP_FLUSH, CFT_OP_FLUSH_EXT: begin
					s_d.busy = 1'b1;
					s_d.flushGo = 1'b1;
					s_d.st = CFT_FLUSH;
				end
				CFT_OP_FMT_TRACK: begin
					if (lbaSel && lbaBad) begin
						s_d.errCause[CFT_ERR_ABORT] = 1'b1;
						s_d.errBit = 1'b1;
						s_d.irqSt[CFT_IRQ_ERR] = 1'b1;
						s_d.irqSt[CFT_IRQ_DONE] = 1'b1;
					end else if (!lbaSel && chsBad) begin
						s_d.errCause[CFT_ERR_IDNF] = 1'b1;
						s_d.errBit = 1'b1;
						s_d.irqSt[CFT_IRQ_ERR] = 1'b1;
						s_d.irqSt[CFT_IRQ_DONE] = 1'b1;
					end else begin
						s_d.busy = 1'b1;
						s_d.fmtGo = 1'b1;
						s_d.trackLba = lbaSel ? lbaTrack : chsTrack;
						s_d.st = CFT_FMT;
					end
				end
				default: begin
					// Unknown opcode is refused at once, busy never rises
					s_d.errCause[CFT_ERR_ABORT] = 1'b1;
					s_d.errBit = 1'b1;
					s_d.irqSt[CFT_IRQ_ERR] = 1'b1;
					s_d.irqSt[CFT_IRQ_DONE] = 1'b1;
				end
			endcase
		end
		// Completions come after the clear above, so a new event is never lost
		if (s_q.st == CFT_FLUSH && flushDone) begin
			s_d.busy = 1'b0;
			s_d.st = CFT_IDLE;
			s_d.irqSt[CFT_IRQ_DONE] = 1'b1;
		end
		if (s_q.st == CFT_FMT && fmtDone) begin
			s_d.busy = 1'b0;
			s_d.st = CFT_IDLE;
			s_d.irqSt[CFT_IRQ_DONE] = 1'b1;
			if (s_q.lbaMode) begin
				s_d.sector = fmtLast[7:0];
				s_d.trkLo = fmtLast[15:8];
				s_d.trkHi = fmtLast[23:16];
				s_d.devHead[CFT_DH_HEAD_MSB:0] = fmtLast[27:24];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s_q <= CORE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Cache flush sequencer
	cft_cache_flush u_flush (
		.mclk(mclk),
		.resetn(resetn),
		.start(s_q.flushGo),
		.done(flushDone),
		.cacheFlushReq(cacheFlushReq),
		.cacheEmpty(cacheEmpty)
	);

	// Track zeroing sequencer
	cft_track_fmt #(
		.SECT_PER_TRACK(SECT_PER_TRACK)
	) u_fmt (
		.mclk(mclk),
		.resetn(resetn),
		.start(s_q.fmtGo),
		.startLba(s_q.trackLba),
		.done(fmtDone),
		.lastLba(fmtLast),
		.mediaWrReq(mediaWrReq),
		.mediaWrLba(mediaWrLba),
		.mediaWrData(mediaWrData),
		.mediaWrAck(mediaWrAck),
		.sectorGood(sectorGood)
	);

	// APB answer: zero wait states, data captured during setup
	assign pready = psel && penable;
	assign prdata = s_q.rdata;
	assign pslverr = pready && s_q.slvErr;
	assign irq = |(s_q.irqSt & s_q.irqMask);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_flush_go;
		cmdWr && opcode == CFT_OP_FLUSH
		|=> s_q.busy && s_q.flushGo && s_q.st == CFT_FLUSH ##1 cacheFlushReq;
	endproperty
	a_flush_go: assert property (p_flush_go) else $error("flush did not start");

	property p_flush_ext_go;
		cmdWr && opcode == CFT_OP_FLUSH_EXT
		|=> s_q.busy && s_q.flushGo && !s_q.fmtGo ##1 cacheFlushReq;
	endproperty
	a_flush_ext_go: assert property (p_flush_ext_go) else $error("ext flush did not start");

	property p_flush_end;
		$fell(s_q.busy) && $past(s_q.st) == CFT_FLUSH |-> $past(flushDone) && !s_q.errBit;
	endproperty
	a_flush_end: assert property (p_flush_end) else $error("flush ended early");

	property p_fmt_go;
		cmdWr && opcode == CFT_OP_FMT_TRACK && !(lbaSel ? lbaBad : chsBad)
		|=> s_q.fmtGo && s_q.busy ##1 !s_q.fmtGo && s_q.busy;
	endproperty
	a_fmt_go: assert property (p_fmt_go) else $error("format did not start once");

	property p_fmt_track;
		s_q.fmtGo && s_q.lbaMode
		|-> s_q.trackLba <= reqLba && reqLba < s_q.trackLba + SECT_PER_TRACK;
	endproperty
	a_fmt_track: assert property (p_fmt_track) else $error("track misses block");

	property p_lba_result;
		fmtDone && s_q.st == CFT_FMT && s_q.lbaMode |=> reqLba == $past(fmtLast) && !s_q.busy;
	endproperty
	a_lba_result: assert property (p_lba_result) else $error("address not left");

	property p_lba_abort;
		cmdWr && opcode == CFT_OP_FMT_TRACK && lbaSel && lbaBad
		|=> s_q.errCause[CFT_ERR_ABORT] && !s_q.busy && !s_q.fmtGo;
	endproperty
	a_lba_abort: assert property (p_lba_abort) else $error("range abort missing");

	property p_abort_err;
		s_q.errCause[CFT_ERR_ABORT] |-> s_q.errBit && !s_q.busy && statusByte[CFT_ST_ERROR];
	endproperty
	a_abort_err: assert property (p_abort_err) else $error("abort without error status");

	c_flush_done: cover property ($past(s_q.st) == CFT_FLUSH && s_q.st == CFT_IDLE);
	c_fmt_done: cover property ($past(s_q.st) == CFT_FMT && s_q.st == CFT_IDLE);
	c_abort: cover property ($rose(s_q.errCause[CFT_ERR_ABORT]));
	c_irq: cover property ($rose(irq));
endmodule

// File: verification/cft_media_model.sv
`timescale 1ns/1ps
module cft_media_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Bench control
	input wire logic clr,
	input wire logic [7:0] ackLat,
	input wire logic [7:0] flushLat,
	input wire logic [cft_pkg::CFT_LBA_W-1:0] badBlock,
	// Cache side
	input wire logic cacheFlushReq,
	output logic cacheEmpty,
	// Media side
	input wire logic mediaWrReq,
	input wire logic [cft_pkg::CFT_LBA_W-1:0] mediaWrLba,
	input wire logic [cft_pkg::CFT_DW-1:0] mediaWrData,
	output logic mediaWrAck,
	output logic sectorGood,
	// Observed traffic
	output logic [7:0] wrCount,
	output logic [cft_pkg::CFT_LBA_W-1:0] firstBlock,
	output logic [cft_pkg::CFT_LBA_W-1:0] lastBlock,
	output logic [7:0] faultCount
);
	import cft_pkg::*;
	logic [7:0] dirtyCnt;
	logic [7:0] waitCnt;
	// Cache only drains while the flush request is held, so an early done is visible
	assign cacheEmpty = (dirtyCnt == 8'h00);
	// One bad sector per run; the format must skip it
	assign sectorGood = (mediaWrLba != badBlock);
	// Ack after a programmable wait, one cycle wide, then record the write
	always_ff @(posedge mclk) begin
		if (!resetn || clr) begin
			dirtyCnt <= clr ? flushLat : 8'h00;
			waitCnt <= 8'h00;
			mediaWrAck <= 1'b0;
			wrCount <= 8'h00;
			faultCount <= 8'h00;
			firstBlock <= '0;
			lastBlock <= '0;
		end else begin
			mediaWrAck <= 1'b0;
			if (cacheFlushReq && dirtyCnt != 8'h00) begin
				dirtyCnt <= dirtyCnt - 8'h01;
			end
			if (mediaWrReq && !mediaWrAck) begin
				waitCnt <= (waitCnt >= ackLat) ? 8'h00 : waitCnt + 8'h01;
				mediaWrAck <= (waitCnt >= ackLat);
			end
			if (mediaWrReq && mediaWrAck) begin
				wrCount <= wrCount + 8'h01;
				lastBlock <= mediaWrLba;
				if (wrCount == 8'h00) begin
					firstBlock <= mediaWrLba;
				end
				// Nonzero data, a bad sector written, or a block at or below the last one written are faults
				if (mediaWrData != CFT_ZERO_WORD || !sectorGood ||
						(wrCount != 8'h00 && mediaWrLba <= lastBlock)) begin
					faultCount <= faultCount + 8'h01;
				end
			end
		end
	end
endmodule

// File: verification/cft_cmd_core_tb.sv
`timescale 1ns/1ps
module cft_cmd_core_tb;
	import cft_pkg::*;
	typedef struct {
		logic [7:0] op, dh, sec, lo, hi, lat;
		logic [27:0] bad;
		logic [7:0] err, wr;
		logic [27:0] first;
		logic [7:0] secOut;
	} cft_row_t;
	// Each error row is followed by a good one so the error register must clear again
	cft_row_t rows [7] = '{
		'{8'h50, 8'hE0, 8'h00, 8'h01, 8'h00, 8'h00, 28'hFFF_FFFF, 8'h04, 8'h00, 28'h0, 8'h00},
		'{8'hE7, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h05, 28'hFFF_FFFF, 8'h00, 8'h00, 28'h0, 8'h00},
		'{8'h50, 8'hA0, 8'h01, 8'h08, 8'h00, 8'h00, 28'hFFF_FFFF, 8'h10, 8'h00, 28'h0, 8'h01},
		'{8'hEA, 8'hA0, 8'h12, 8'h34, 8'h56, 8'h02, 28'hFFF_FFFF, 8'h00, 8'h00, 28'h0, 8'h12},
		'{8'h99, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h00, 28'hFFF_FFFF, 8'h04, 8'h00, 28'h0, 8'h00},
		'{8'h50, 8'hE0, 8'h06, 8'h00, 8'h00, 8'h00, 28'h000_0005, 8'h00, 8'h03, 28'h4, 8'h07},
		'{8'h50, 8'hA2, 8'h01, 8'h01, 8'h00, 8'h03, 28'hFFF_FFFF, 8'h00, 8'h04, 28'h48, 8'h01}};
	logic mclk, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, lastErr, cacheFlushReq, cacheEmpty, irq;
	logic mediaWrReq, mediaWrAck, sectorGood;
	logic [27:0] mediaWrLba, badBlock = 28'hFFF_FFFF, firstBlock, lastBlock;
	logic [31:0] mediaWrData;
	logic [7:0] ackLat = 8'h00, flushLat = 8'h00, wrCount, faultCount;
	int failCount = 0, numChecks = 0, cycles = 0;
	// Small geometry keeps a track at four sectors and the range checks reachable
	cft_cmd_core #(.SECT_PER_TRACK(4), .HEADS(16), .CYLINDERS(8), .MAX_LBA(28'h000_00FF))
		i_cft_cmd_core (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cacheFlushReq(cacheFlushReq), .cacheEmpty(cacheEmpty),
		.mediaWrReq(mediaWrReq), .mediaWrLba(mediaWrLba), .mediaWrData(mediaWrData),
		.mediaWrAck(mediaWrAck), .sectorGood(sectorGood), .irq(irq));
	cft_media_model i_cft_media_model (.mclk(mclk), .resetn(resetn), .clr(clr),
		.ackLat(ackLat), .flushLat(flushLat), .badBlock(badBlock),
		.cacheFlushReq(cacheFlushReq), .cacheEmpty(cacheEmpty), .mediaWrReq(mediaWrReq),
		.mediaWrLba(mediaWrLba), .mediaWrData(mediaWrData), .mediaWrAck(mediaWrAck),
		.sectorGood(sectorGood), .wrCount(wrCount), .firstBlock(firstBlock),
		.lastBlock(lastBlock), .faultCount(faultCount));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Hang guard, far beyond the few hundred cycles the run needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failCount++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		numChecks++;
		if (g !== e) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; request held until pready is seen at a rising edge
	// No wait limit here: only the hang guard may end a stalled transfer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Poll status until busy drops, bounded
	task automatic waitIdle();
		int n;
		n = 0;
		do begin
			apb(1'b0, CFT_OFS_STATUS, 32'h0);
			n++;
		end while (rd[CFT_ST_BUSY] !== 1'b0 && n < 300);
		chk("busy", 32'h0, {31'h0, rd[CFT_ST_BUSY]});
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		// Reset values and an unmapped place
		apb(1'b0, CFT_OFS_DEVHEAD, 32'h0);
		chk("devhead", 32'h0000_00A0, rd);
		apb(1'b0, CFT_OFS_STATUS, 32'h0);
		chk("status", 32'h0000_0050, rd);
		apb(1'b0, CFT_OFS_IRQ_MASK, 32'h0);
		chk("mask", 32'h0000_0000, rd);
		apb(1'b0, 12'h030, 32'h0);
		chk("unmapped", 32'h0000_0001, {rd[30:0], lastErr});
		foreach (rows[i]) begin
			@(posedge mclk);
			clr <= 1'b1;
			ackLat <= rows[i].lat;
			flushLat <= {rows[i].lat[5:0], 2'b01};
			badBlock <= rows[i].bad;
			@(posedge mclk);
			clr <= 1'b0;
			apb(1'b1, CFT_OFS_DEVHEAD, {24'h0, rows[i].dh});
			apb(1'b1, CFT_OFS_SECTOR, {24'h0, rows[i].sec});
			apb(1'b1, CFT_OFS_TRK_LO, {24'h0, rows[i].lo});
			apb(1'b1, CFT_OFS_TRK_HI, {24'h0, rows[i].hi});
			if (rows[i].op == CFT_OP_FMT_TRACK) begin
				repeat (2) apb(1'b1, CFT_OFS_DATA, 32'hFFFF_FFFF);
			end
			apb(1'b1, CFT_OFS_OPCODE, {24'h0, rows[i].op});
			waitIdle();
			apb(1'b0, CFT_OFS_ERROR, 32'h0);
			chk("error", {24'h0, rows[i].err}, rd);
			apb(1'b0, CFT_OFS_STATUS, 32'h0);
			chk("status", {24'h0, 7'h28, rows[i].err != 8'h00}, rd);
			chk("writes", {24'h0, rows[i].wr}, {24'h0, wrCount});
			chk("faults", 32'h0, {24'h0, faultCount});
			if (rows[i].wr != 8'h00) begin
				chk("first", {4'h0, rows[i].first}, {4'h0, firstBlock});
				chk("last", {4'h0, rows[i].first + 28'h3}, {4'h0, lastBlock});
			end
			apb(1'b0, CFT_OFS_SECTOR, 32'h0);
			chk("sector", {24'h0, rows[i].secOut}, rd);
		end
		// Interrupt: every command ended with done, the aborts with error
		apb(1'b0, CFT_OFS_IRQ_ST, 32'h0);
		chk("irqst", 32'h0000_0003, rd);
		chk("irq", 32'h0, {31'h0, irq});
		// The write lands at the edge the task returns on, so irq is looked at half a cycle later
		apb(1'b1, CFT_OFS_IRQ_MASK, 32'h0000_0001);
		@(negedge mclk);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, CFT_OFS_IRQ_ST, 32'h0000_0003);
		@(negedge mclk);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b0, CFT_OFS_IRQ_ST, 32'h0);
		chk("irqst", 32'h0000_0000, rd);
		// Slow drain: busy must hold and parameter writes must bounce
		@(posedge mclk);
		clr <= 1'b1;
		flushLat <= 8'h50;
		@(posedge mclk);
		clr <= 1'b0;
		apb(1'b1, CFT_OFS_SECTOR, 32'h0000_0011);
		apb(1'b1, CFT_OFS_OPCODE, {24'h0, CFT_OP_FLUSH});
		apb(1'b0, CFT_OFS_STATUS, 32'h0);
		chk("status", 32'h0000_00D0, rd);
		apb(1'b1, CFT_OFS_SECTOR, 32'h0000_0055);
		waitIdle();
		apb(1'b0, CFT_OFS_SECTOR, 32'h0);
		chk("sector", 32'h0000_0011, rd);
		// Reset once the drain has ended: command block and interrupt state fall back to reset values
		@(posedge mclk);
		resetn <= 1'b0;
		@(posedge mclk);
		resetn <= 1'b1;
		apb(1'b0, CFT_OFS_SECTOR, 32'h0);
		chk("rst sector", 32'h0000_0000, rd);
		apb(1'b0, CFT_OFS_DEVHEAD, 32'h0);
		chk("rst devhead", 32'h0000_00A0, rd);
		apb(1'b0, CFT_OFS_IRQ_ST, 32'h0);
		chk("rst irqst", 32'h0000_0000, rd);
		chk("rst irq", 32'h0, {31'h0, irq});
		conclude();
	end
endmodule
